// *** verilog/msd_pkg.sv ***
/*
  Package for the memory space, page and decode block: offsets, field
  positions, reset values and sizes shared by the design files.
  Assumes nothing of its surroundings.
*/
package msd_pkg;

  // Configuration block offsets (byte offsets above the block base)
  localparam logic [7:0] OFS_PAGE      = 8'he0;
  localparam logic [7:0] OFS_SPACE_MAP = 8'he2;
  localparam logic [7:0] OFS_MEM_ID0   = 8'hf0;
  localparam logic [7:0] OFS_MEM_ID1   = 8'hf1;
  localparam logic [7:0] OFS_PMGT0     = 8'hb0;
  localparam logic [7:0] OFS_PMGT2     = 8'hb4;

  // Space-mapping register fields
  localparam int SM_SRAM_CODE  = 0;
  localparam int SM_SEC_CODE   = 1;
  localparam int SM_PRI_CODE   = 2;
  localparam int SM_SEC_DATA   = 3;
  localparam int SM_PRI_DATA   = 4;

  // Power-management fields
  localparam int PM0_TURBO_OFF = 3;
  localparam int PM2_GATE_W    = 5;

  // Reset values
  localparam logic [7:0] PAGE_RST      = 8'h00;
  localparam logic [7:0] SPACE_MAP_RST = 8'h0c;
  localparam logic [7:0] PMGT0_RST     = 8'h00;
  localparam logic [7:0] PMGT2_RST     = 8'h00;

  // Memory ID values, arbitrary
  localparam logic [7:0] MEM_ID0_VAL   = 8'h5a;
  localparam logic [7:0] MEM_ID1_VAL   = 8'ha5;

  // Sizes
  localparam int PAGE_W      = 8;
  localparam int ADDR_W      = 20;
  localparam int PLD_ADDR_W  = 16;
  localparam int PRI_SECT_N  = 16;
  localparam int SEC_SECT_N  = 4;
  localparam int PT_N        = 3;
  localparam int ECS_N       = 3;
  localparam int PORT_IN_W   = 36;
  localparam int FB_W        = 16;
  localparam int PLD_BUS_W   = 82;
  localparam int CTRL_W      = 3;
  localparam int WIN_W       = 2 * PLD_BUS_W;

  // Standby after idle inputs
  localparam int CLK_MHZ     = 200;
  localparam int IDLE_NS     = 70;
  localparam int IDLE_CYC    = (IDLE_NS * CLK_MHZ) / 1000;
  localparam logic [3:0] IDLE_CNT_MAX = 4'(IDLE_CYC);

endpackage

// *** verilog/msd_term_match.sv ***
/*
  One product-term OR group: up to three address-window terms over the
  PLD input bus. Each term is a mask/value pair, hit when its mask is nonzero and masked bits match.
  Assumes static configuration inputs.
*/
`timescale 1ns/1ps
module msd_term_match (
  // Input bus and terms
  input  wire logic [msd_pkg::PLD_BUS_W-1:0]          pld_bus,
  input  wire logic [msd_pkg::PT_N*msd_pkg::WIN_W-1:0] terms,
  // Result
  output logic                                         hit
);
  logic [msd_pkg::PT_N-1:0] pt;

  genvar i;
  generate
    for (i = 0; i < msd_pkg::PT_N; i++) begin : g_pt
      logic [msd_pkg::PLD_BUS_W-1:0] msk;
      logic [msd_pkg::PLD_BUS_W-1:0] val;
      assign msk = terms[i*msd_pkg::WIN_W +: msd_pkg::PLD_BUS_W];
      assign val = terms[i*msd_pkg::WIN_W + msd_pkg::PLD_BUS_W +: msd_pkg::PLD_BUS_W];
      assign pt[i] = (msk != '0) && ((pld_bus & msk) == (val & msk));
    end
  endgenerate

  assign hit = |pt;
endmodule

// *** verilog/msd_idle_timer.sv ***
/*
  Standby timer: counts cycles with an unchanged input bus and raises
  standby when the idle time is reached while turbo is off.
  Assumes synchronous reset on clk.
*/
`timescale 1ns/1ps
module msd_idle_timer (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         sys_rst,
  // Control
  input  wire logic                         turbo_off,
  input  wire logic [msd_pkg::PLD_BUS_W-1:0] pld_bus,
  // Status
  output logic                              standby
);
  logic [msd_pkg::PLD_BUS_W-1:0] last_reg;
  logic [3:0]                    cnt_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_reg <= '0;
    end else begin
      last_reg <= pld_bus;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || !turbo_off || (pld_bus != last_reg)) begin
      cnt_reg <= 4'h0;
    end else if (cnt_reg != msd_pkg::IDLE_CNT_MAX) begin
      cnt_reg <= cnt_reg + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      standby <= 1'b0;
    end else begin
      standby <= turbo_off && (pld_bus == last_reg) && (cnt_reg == msd_pkg::IDLE_CNT_MAX);
    end
  end
endmodule

// *** verilog/msd_decode.sv ***
/*
  Memory space mapping, page register, memory ID registers, PLD input bus
  and decode select outputs. Registers sit on the MCU strobe bus at
  offsets above the configuration block base.
  Assumes MCU bus pins are asynchronous and are synchronised here;
  decode terms are static configuration held by the surroundings.
*/
`timescale 1ns/1ps

// Notes on behaviour
// - Fetch strobe is code space, read strobe data
// - Each memory mapped to code, data or both
// - Space map loads initial value, writable live
// - Value 0Ch: primary code, others data only
// - Bits 2 and 4 put primary in both
// - Page register is eight bits, read/write
// - Page register at block offset E0h
// - Page bits feed decode select equations
// - Page bits also feed general logic
// - Two read-only memory ID registers
// - Turbo off: standby after 70ns idle inputs
// - Four bits gate control lines and reset off PLDs
// - Input bus carries 82 signals
// - Extended mode takes address lines A19-A4
// - Sector selects and SRAM select, three terms
// - Config, test-port and two peripheral selects
// - Decode works from reset, no setup
// - General logic drives three chip selects
// - Secondary beats primary; SRAM/IO beat flash
module msd_decode (
  // Clock and reset
  input  wire logic                                          clk,
  input  wire logic                                          sys_rst,
  // MCU bus pins
  input  wire logic [msd_pkg::ADDR_W-1:0]                    mcu_addr,
  input  wire logic [7:0]                                    mcu_wdata,
  input  wire logic                                          mcu_wr_n,
  input  wire logic                                          read_strobe_n,
  input  wire logic                                          program_fetch_strobe_n,
  input  wire logic                                          extended_addr_mode,
  // Other PLD inputs
  input  wire logic                                          power_down_indicator,
  input  wire logic [msd_pkg::PORT_IN_W-1:0]                 port_pins,
  input  wire logic [msd_pkg::FB_W-1:0]                      macrocell_fb,
  input  wire logic                                          flash_ready,
  // Decode configuration
  input  wire logic [msd_pkg::PRI_SECT_N*msd_pkg::PT_N*msd_pkg::WIN_W-1:0] pri_terms,
  input  wire logic [msd_pkg::SEC_SECT_N*msd_pkg::PT_N*msd_pkg::WIN_W-1:0] sec_terms,
  input  wire logic [msd_pkg::PT_N*msd_pkg::WIN_W-1:0]       sram_terms,
  input  wire logic [msd_pkg::PT_N*msd_pkg::WIN_W-1:0]       cfg_terms,
  input  wire logic [msd_pkg::PT_N*msd_pkg::WIN_W-1:0]       test_terms,
  input  wire logic [2*msd_pkg::PT_N*msd_pkg::WIN_W-1:0]     periph_terms,
  input  wire logic [msd_pkg::ECS_N*msd_pkg::PT_N*msd_pkg::WIN_W-1:0] ecs_terms,
  // Register read data
  output logic [7:0]                                         mcu_rdata,
  output logic                                               mcu_rdata_oe,
  // Selects
  output logic [msd_pkg::PRI_SECT_N-1:0]                     primary_sector_selects,
  output logic [msd_pkg::SEC_SECT_N-1:0]                     secondary_sector_selects,
  output logic                                               sram_select,
  output logic                                               config_block_select,
  output logic                                               test_port_select,
  output logic [1:0]                                         periph_selects,
  output logic [msd_pkg::ECS_N-1:0]                          external_chip_selects,
  // Page bits to general logic, status
  output logic [msd_pkg::PAGE_W-1:0]                         page_bits,
  output logic                                               pld_standby
);

  // Synchronisers
  logic [msd_pkg::ADDR_W-1:0] addr_s1_reg;
  logic [msd_pkg::ADDR_W-1:0] addr_reg;
  logic [7:0]                 wd_s1_reg;
  logic [7:0]                 wd_reg;
  logic [5:0]                 ctl_s1_reg;
  logic [5:0]                 ctl_reg;
  logic [msd_pkg::PORT_IN_W+msd_pkg::FB_W+1:0] oth_s1_reg;
  logic [msd_pkg::PORT_IN_W+msd_pkg::FB_W+1:0] oth_reg;
  logic                       ext_s1_reg;
  logic                       ext_reg;

  // Address and write data
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      addr_s1_reg <= '0;
      addr_reg    <= '0;
      wd_s1_reg   <= 8'h00;
      wd_reg      <= 8'h00;
    end else begin
      addr_s1_reg <= mcu_addr;
      addr_reg    <= addr_s1_reg;
      wd_s1_reg   <= mcu_wdata;
      wd_reg      <= wd_s1_reg;
    end
  end

  // Strobes and address mode strap
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctl_s1_reg  <= 6'h07;
      ctl_reg     <= 6'h07;
      ext_s1_reg  <= 1'b0;
      ext_reg     <= 1'b0;
    end else begin
      ctl_s1_reg  <= {3'h0, mcu_wr_n, read_strobe_n, program_fetch_strobe_n};
      ctl_reg     <= {ctl_s1_reg[5:3], ctl_s1_reg[2:0]};
      ext_s1_reg  <= extended_addr_mode;
      ext_reg     <= ext_s1_reg;
    end
  end

  // Other PLD bus inputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      oth_s1_reg  <= '0;
      oth_reg     <= '0;
    end else begin
      oth_s1_reg  <= {flash_ready, power_down_indicator, macrocell_fb, port_pins};
      oth_reg     <= oth_s1_reg;
    end
  end

  logic fetch_act;
  logic read_act;
  logic wr_act;
  logic wr_prev_reg;
  assign fetch_act = !ctl_reg[0];
  assign read_act  = !ctl_reg[1];
  assign wr_act    = !ctl_reg[2];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wr_prev_reg <= 1'b0;
    end else begin
      wr_prev_reg <= wr_act;
    end
  end

  // Registers
  logic [7:0]                 page_reg;
  logic [7:0]                 space_map_reg;
  logic [7:0]                 pmgt0_reg;
  logic [7:0]                 pmgt2_reg;
  logic                       wr_pulse;
  logic                       cfg_hit;
  logic [7:0]                 reg_ofs;

  assign reg_ofs  = addr_reg[7:0];
  assign wr_pulse = wr_act && !wr_prev_reg && cfg_hit;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page_reg <= msd_pkg::PAGE_RST;
    end else if (wr_pulse && reg_ofs == msd_pkg::OFS_PAGE) begin
      page_reg <= wd_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      space_map_reg <= msd_pkg::SPACE_MAP_RST;
    end else if (wr_pulse && reg_ofs == msd_pkg::OFS_SPACE_MAP) begin
      space_map_reg <= wd_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pmgt0_reg <= msd_pkg::PMGT0_RST;
    end else if (wr_pulse && reg_ofs == msd_pkg::OFS_PMGT0) begin
      pmgt0_reg <= wd_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pmgt2_reg <= msd_pkg::PMGT2_RST;
    end else if (wr_pulse && reg_ofs == msd_pkg::OFS_PMGT2) begin
      pmgt2_reg <= wd_reg;
    end
  end

  // Control lines gated off the PLD bus by power bits
  logic [msd_pkg::CTRL_W-1:0] ctl_pld;
  assign ctl_pld = {~ctl_reg[0], ~ctl_reg[1], ~ctl_reg[2]} & ~pmgt2_reg[2:0];

  // PLD input bus
  logic [msd_pkg::PLD_ADDR_W-1:0] pld_addr;
  logic [msd_pkg::PLD_BUS_W-1:0]  pld_bus;
  assign pld_addr = ext_reg ? addr_reg[19:4] : addr_reg[15:0];
  assign pld_bus  = {oth_reg[msd_pkg::PORT_IN_W+msd_pkg::FB_W+1],
                     page_reg,
                     oth_reg[msd_pkg::PORT_IN_W+msd_pkg::FB_W:0],
                     sys_rst & ~pmgt2_reg[3],
                     ctl_pld,
                     pld_addr};

  // Decode terms
  logic [msd_pkg::PRI_SECT_N-1:0] pri_hit;
  logic [msd_pkg::SEC_SECT_N-1:0] sec_hit;
  logic                           sram_hit;
  logic                           test_hit;
  logic [1:0]                     per_hit;
  logic [msd_pkg::ECS_N-1:0]      ecs_hit;

  genvar gi;
  generate
    for (gi = 0; gi < msd_pkg::PRI_SECT_N; gi++) begin : g_pri
      msd_term_match u_m (
        .pld_bus (pld_bus),
        .terms   (pri_terms[gi*msd_pkg::PT_N*msd_pkg::WIN_W +: msd_pkg::PT_N*msd_pkg::WIN_W]),
        .hit     (pri_hit[gi])
      );
    end
    for (gi = 0; gi < msd_pkg::SEC_SECT_N; gi++) begin : g_sec
      msd_term_match u_m (
        .pld_bus (pld_bus),
        .terms   (sec_terms[gi*msd_pkg::PT_N*msd_pkg::WIN_W +: msd_pkg::PT_N*msd_pkg::WIN_W]),
        .hit     (sec_hit[gi])
      );
    end
    for (gi = 0; gi < 2; gi++) begin : g_per
      msd_term_match u_m (
        .pld_bus (pld_bus),
        .terms   (periph_terms[gi*msd_pkg::PT_N*msd_pkg::WIN_W +: msd_pkg::PT_N*msd_pkg::WIN_W]),
        .hit     (per_hit[gi])
      );
    end
    for (gi = 0; gi < msd_pkg::ECS_N; gi++) begin : g_ecs
      msd_term_match u_m (
        .pld_bus (pld_bus),
        .terms   (ecs_terms[gi*msd_pkg::PT_N*msd_pkg::WIN_W +: msd_pkg::PT_N*msd_pkg::WIN_W]),
        .hit     (ecs_hit[gi])
      );
    end
  endgenerate

  msd_term_match u_sram (
    .pld_bus (pld_bus),
    .terms   (sram_terms),
    .hit     (sram_hit)
  );
  msd_term_match u_cfg (
    .pld_bus (pld_bus),
    .terms   (cfg_terms),
    .hit     (cfg_hit)
  );
  msd_term_match u_test (
    .pld_bus (pld_bus),
    .terms   (test_terms),
    .hit     (test_hit)
  );

  // Space qualification
  logic pri_ok;
  logic sec_ok;
  logic sram_ok;
  logic io_ok;
  assign pri_ok  = (fetch_act && space_map_reg[msd_pkg::SM_PRI_CODE])
                || (read_act && space_map_reg[msd_pkg::SM_PRI_DATA]);
  assign sec_ok  = (fetch_act && space_map_reg[msd_pkg::SM_SEC_CODE])
                || (read_act && space_map_reg[msd_pkg::SM_SEC_DATA]);
  assign sram_ok = (fetch_act && space_map_reg[msd_pkg::SM_SRAM_CODE])
                || read_act || wr_act;
  assign io_ok   = read_act || wr_act;

  logic high_pri;
  logic sec_any;
  assign high_pri = (sram_hit && sram_ok) || (cfg_hit && io_ok) || (|per_hit && io_ok);
  assign sec_any  = |sec_hit && sec_ok;

  // Registered selects; active from reset release without setup
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      primary_sector_selects   <= '0;
      secondary_sector_selects <= '0;
    end else begin
      primary_sector_selects   <= (pri_ok && !sec_any && !high_pri) ? pri_hit : '0;
      secondary_sector_selects <= (sec_ok && !high_pri) ? sec_hit : '0;
    end
  end

  // SRAM, configuration and peripheral selects
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sram_select              <= 1'b0;
      config_block_select      <= 1'b0;
      periph_selects           <= 2'h0;
      test_port_select         <= 1'b0;
    end else begin
      sram_select              <= sram_hit && sram_ok;
      config_block_select      <= cfg_hit && io_ok;
      periph_selects           <= io_ok ? per_hit : 2'h0;
      test_port_select         <= test_hit;
    end
  end

  // External chip selects from the general logic terms
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      external_chip_selects    <= '0;
    end else begin
      external_chip_selects    <= ecs_hit;
    end
  end

  // Register read-back
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mcu_rdata_oe <= 1'b0;
    end else begin
      mcu_rdata_oe <= read_act && cfg_hit;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mcu_rdata    <= 8'h00;
    end else begin
      unique case (reg_ofs)
        msd_pkg::OFS_PAGE:      mcu_rdata <= page_reg;
        msd_pkg::OFS_SPACE_MAP: mcu_rdata <= space_map_reg;
        msd_pkg::OFS_MEM_ID0:   mcu_rdata <= msd_pkg::MEM_ID0_VAL;
        msd_pkg::OFS_MEM_ID1:   mcu_rdata <= msd_pkg::MEM_ID1_VAL;
        msd_pkg::OFS_PMGT0:     mcu_rdata <= pmgt0_reg;
        msd_pkg::OFS_PMGT2:     mcu_rdata <= pmgt2_reg;
        default:                mcu_rdata <= 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      page_bits <= msd_pkg::PAGE_RST;
    end else begin
      page_bits <= page_reg;
    end
  end

  msd_idle_timer u_idle (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .turbo_off (!pmgt0_reg[msd_pkg::PM0_TURBO_OFF]),
    .pld_bus   (pld_bus),
    .standby   (pld_standby)
  );

endmodule

// *** testbench/msd_checker_assertions.sv ***
/*
  Port checker for the decode block.
  Assumes it is bound to msd_decode and sees only its ports.
*/
`timescale 1ns/1ps
module msd_checker (
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Bus pins
  input wire logic [19:0] mcu_addr,
  input wire logic        mcu_wr_n,
  input wire logic        read_strobe_n,
  input wire logic        program_fetch_strobe_n,
  // Outputs
  input wire logic        mcu_rdata_oe,
  input wire logic [15:0] primary_sector_selects,
  input wire logic [3:0]  secondary_sector_selects,
  input wire logic        sram_select,
  input wire logic        config_block_select,
  input wire logic [1:0]  periph_selects,
  input wire logic [7:0]  page_bits,
  input wire logic        pld_standby
);
  wire any_stb = !program_fetch_strobe_n || !read_strobe_n || !mcu_wr_n;
  wire io_hit  = sram_select || config_block_select || (|periph_selects);

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_page_rst: assert property ($fell(sys_rst) |-> page_bits == 8'h00)
    else $error("page bits not clear after reset");
  a_page_write: assert property ($changed(page_bits) |-> $past(sys_rst) || !$past(mcu_wr_n, 3))
    else $error("page bits changed without a write");
  a_sec_over_pri: assert property (|secondary_sector_selects |-> primary_sector_selects == 16'h0000)
    else $error("primary select beside secondary select");
  a_io_over_flash: assert property (io_hit |-> primary_sector_selects == 16'h0000
                                    && secondary_sector_selects == 4'h0)
    else $error("flash select beside sram or io select");
  a_flash_strobe: assert property (|primary_sector_selects |-> $past(any_stb, 3))
    else $error("primary select without strobe");
  a_sram_strobe: assert property (sram_select |-> $past(any_stb, 3))
    else $error("sram select without strobe");
  a_rdata_oe: assert property (mcu_rdata_oe |-> !$past(read_strobe_n, 3))
    else $error("read data driven without read strobe");
  a_standby_idle: assert property ($rose(pld_standby) |-> $past(mcu_addr, 4) == $past(mcu_addr, 12))
    else $error("standby while address moving");

  c_sram: cover property (sram_select);
  c_sec: cover property (|secondary_sector_selects);
  c_stby: cover property ($rose(pld_standby));
endmodule

bind msd_decode msd_checker u_chk (.clk, .sys_rst, .mcu_addr, .mcu_wr_n, .read_strobe_n,
  .program_fetch_strobe_n, .mcu_rdata_oe, .primary_sector_selects, .secondary_sector_selects,
  .sram_select, .config_block_select, .periph_selects, .page_bits, .pld_standby);

// *** testbench/msd_mcu_model.sv ***
/*
  Host MCU bus model: strobe-qualified writes, reads and held accesses.
  Assumes inputs are changed at the falling clock edge.
*/
`timescale 1ns/1ps
module msd_mcu_model (
  // Clock
  input wire logic        clk,
  // Bus pins
  output logic [19:0]     mcu_addr,
  output logic [7:0]      mcu_wdata,
  output logic            mcu_wr_n,
  output logic            read_strobe_n,
  output logic            program_fetch_strobe_n,
  // Read data
  input wire logic [7:0]  mcu_rdata
);
  initial begin
    mcu_addr = 20'h00000;
    mcu_wdata = 8'h00;
    mcu_wr_n = 1'b1;
    read_strobe_n = 1'b1;
    program_fetch_strobe_n = 1'b1;
  end

  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic wr(input logic [19:0] a, input logic [7:0] d);
    mcu_addr = a;
    mcu_wdata = d;
    gap(3);
    mcu_wr_n = 1'b0;
    gap(4);
    mcu_wr_n = 1'b1;
    gap(4);
    mcu_wdata = ~d;
  endtask

  task automatic rd(input logic [19:0] a, output logic [7:0] d);
    mcu_addr = a;
    gap(3);
    read_strobe_n = 1'b0;
    gap(5);
    d = mcu_rdata;
    read_strobe_n = 1'b1;
    gap(4);
  endtask

  // Fetch strobe for code, read strobe for data; held until idle
  task automatic acc(input logic [19:0] a, input logic f, input logic r);
    mcu_addr = a;
    gap(3);
    program_fetch_strobe_n = !f;
    read_strobe_n = !r;
    gap(5);
  endtask

  task automatic idle();
    program_fetch_strobe_n = 1'b1;
    read_strobe_n = 1'b1;
    gap(5);
  endtask
endmodule

// *** testbench/memory_space_page_decode_tb.sv ***
/*
  Testbench for the decode block: registers, space map, priority,
  extended address, selects, gating and standby.
  Assumes msd_pkg and the design files are compiled first.
*/
`timescale 1ns/1ps
module memory_space_page_decode_tb;
  logic           clk;
  logic           sys_rst;
  logic           ext_mode;
  logic [35:0]    pins;
  logic [15:0]    fb;
  logic [7:0]     rdata;
  logic [7:0]     d;
  logic [15:0]    pri;
  logic [3:0]     sec;
  logic           sram;
  logic           cfg;
  logic           tst;
  logic [1:0]     per;
  logic [2:0]     ecs;
  logic [7:0]     page;
  logic           stby;
  logic           oe;
  logic [19:0]    addr;
  logic [7:0]     wdata;
  logic           wr_n;
  logic           rd_n;
  logic           fe_n;
  logic [7871:0]  pri_t;
  logic [1967:0]  sec_t;
  logic [491:0]   sram_t;
  logic [491:0]   cfg_t;
  logic [491:0]   test_t;
  logic [983:0]   per_t;
  logic [1475:0]  ecs_t;
  int             n_fail;
  int             checked;

  msd_decode u_dut (.clk(clk), .sys_rst(sys_rst), .mcu_addr(addr), .mcu_wdata(wdata),
    .mcu_wr_n(wr_n), .read_strobe_n(rd_n), .program_fetch_strobe_n(fe_n),
    .extended_addr_mode(ext_mode), .power_down_indicator(1'b0), .port_pins(pins),
    .macrocell_fb(fb), .flash_ready(1'b1), .pri_terms(pri_t), .sec_terms(sec_t),
    .sram_terms(sram_t), .cfg_terms(cfg_t), .test_terms(test_t), .periph_terms(per_t),
    .ecs_terms(ecs_t), .mcu_rdata(rdata), .mcu_rdata_oe(oe), .primary_sector_selects(pri),
    .secondary_sector_selects(sec), .sram_select(sram), .config_block_select(cfg),
    .test_port_select(tst), .periph_selects(per), .external_chip_selects(ecs),
    .page_bits(page), .pld_standby(stby));

  msd_mcu_model u_mcu (.clk(clk), .mcu_addr(addr), .mcu_wdata(wdata), .mcu_wr_n(wr_n),
    .read_strobe_n(rd_n), .program_fetch_strobe_n(fe_n), .mcu_rdata(rdata));

  function automatic logic [163:0] tm(input logic [81:0] v, input logic [81:0] m);
    return {v & m, m};
  endfunction

  function automatic logic [19:0] ca(input logic [7:0] o);
    return {12'h003, o};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wrap_up();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic t_reset();
    chk("page_bits", 16'h0000, page);
    u_mcu.rd(ca(8'hf0), d);
    chk("id0", 16'h005a, d);
    u_mcu.rd(ca(8'hf1), d);
    chk("id1", 16'h00a5, d);
    u_mcu.rd(ca(8'he2), d);
    chk("space_map", 16'h000c, d);
  endtask

  task automatic t_page();
    u_mcu.wr(ca(8'he0), 8'h96);
    chk("page_bits", 16'h0096, page);
    u_mcu.rd(ca(8'he0), d);
    chk("page_rd", 16'h0096, d);
    u_mcu.wr(ca(8'hf0), 8'h00);
    u_mcu.rd(ca(8'hf0), d);
    chk("id0_ro", 16'h005a, d);
    u_mcu.rd(ca(8'h10), d);
    chk("unmapped", 16'h0000, d);
    u_mcu.acc(20'h02000, 1'b0, 1'b1);
    chk("sram_page", 16'h0001, sram);
    u_mcu.idle();
  endtask

  task automatic t_space();
    u_mcu.acc(20'h08000, 1'b1, 1'b0);
    chk("pri_fetch", 16'h0001, pri);
    u_mcu.idle();
    u_mcu.acc(20'h08000, 1'b0, 1'b1);
    chk("pri_read", 16'h0000, pri);
    u_mcu.idle();
    u_mcu.acc(20'h09000, 1'b0, 1'b1);
    chk("sec_read", 16'h0001, sec);
    u_mcu.idle();
    u_mcu.acc(20'h09000, 1'b1, 1'b0);
    chk("sec_fetch", 16'h0000, sec);
    u_mcu.idle();
    u_mcu.wr(ca(8'he2), 8'h03);
    u_mcu.acc(20'h09000, 1'b1, 1'b0);
    chk("sec_code", 16'h0001, sec);
    u_mcu.idle();
    u_mcu.acc(20'h02000, 1'b1, 1'b0);
    chk("sram_code", 16'h0001, sram);
    u_mcu.idle();
    u_mcu.wr(ca(8'he2), 8'h14);
    u_mcu.acc(20'h08000, 1'b0, 1'b1);
    chk("pri_both", 16'h0001, pri);
    u_mcu.idle();
  endtask

  task automatic t_prio();
    u_mcu.wr(ca(8'he2), 8'h1c);
    u_mcu.acc(20'h08000, 1'b0, 1'b1);
    chk("sec_win", 16'h0002, sec);
    chk("pri_lose", 16'h0000, pri);
    u_mcu.idle();
    u_mcu.acc(20'h08400, 1'b0, 1'b1);
    chk("sram_win", 16'h0001, sram);
    chk("flash_lose", 16'h0000, {pri[11:0], sec});
    u_mcu.idle();
  endtask

  task automatic t_ext();
    ext_mode = 1'b1;
    u_mcu.acc(20'h80000, 1'b1, 1'b0);
    chk("ext_hi", 16'h0001, pri);
    u_mcu.idle();
    u_mcu.acc(20'h08000, 1'b1, 1'b0);
    chk("ext_lo", 16'h0000, pri);
    u_mcu.idle();
    ext_mode = 1'b0;
  endtask

  task automatic t_sel();
    pins = 36'h000000003;
    u_mcu.acc(ca(8'h00), 1'b0, 1'b1);
    chk("cfg_tst", 16'h0003, {cfg, tst});
    chk("ecs_per", 16'h0005, {ecs, per});
    chk("rdata_oe", 16'h0001, oe);
    u_mcu.idle();
  endtask

  task automatic t_gate();
    u_mcu.wr(ca(8'hb4), 8'h02);
    u_mcu.acc(ca(8'h00), 1'b0, 1'b1);
    chk("gated", 16'h0000, tst);
    u_mcu.idle();
    u_mcu.wr(ca(8'hb4), 8'h00);
  endtask

  task automatic t_standby();
    u_mcu.gap(25);
    chk("standby", 16'h0001, stby);
    u_mcu.wr(ca(8'hb0), 8'h08);
    u_mcu.gap(25);
    chk("turbo", 16'h0000, stby);
  endtask

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    #100000;
    n_fail++;
    wrap_up();
  end

  initial begin
    n_fail = 0;
    checked = 0;
    sys_rst = 1'b1;
    ext_mode = 1'b0;
    pins = '0;
    fb = 16'h0000;
    pri_t = '0;
    sec_t = '0;
    sram_t = '0;
    cfg_t = '0;
    test_t = '0;
    per_t = '0;
    ecs_t = '0;
    pri_t[163:0] = tm(82'h8000, 82'hf000);
    sec_t[163:0] = tm(82'h9000, 82'hf000);
    sec_t[655:492] = tm(82'h8000, 82'hf800);
    sram_t[163:0] = tm((82'h96 << 73) | 82'h2000, (82'hff << 73) | 82'hf000);
    sram_t[327:164] = tm(82'h8400, 82'hff00);
    cfg_t[163:0] = tm(82'h0300, 82'hff00);
    test_t[163:0] = tm((82'h1 << 17) | 82'h0300, (82'h1 << 17) | 82'hff00);
    per_t[163:0] = tm(82'h1 << 21, 82'h1 << 21);
    ecs_t[163:0] = tm(82'h1 << 20, 82'h1 << 20);
    repeat (4) @(negedge clk);
    sys_rst = 1'b0;
    u_mcu.gap(3);
    t_reset();
    t_page();
    t_space();
    t_prio();
    t_ext();
    t_sel();
    t_gate();
    t_standby();
    wrap_up();
  end
endmodule
